// ==== rcl_pkg.sv ====
// constants for the reset configuration latch
package rcl_pkg;
  localparam int LATCH_LEAD = 4;
  localparam int CNT_W = 12;
  localparam logic [1:0] BOOT_DEFAULT = 2'h0;
  localparam logic [1:0] CLK_DEFAULT = 2'h2;
  localparam logic RANGE_DEFAULT = 1'h0;
  // boot source codes
  localparam logic [1:0] BOOT_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SERIAL = 2'h1;
  localparam logic [1:0] BOOT_EXT_SINGLE = 2'h2;
  localparam logic [1:0] BOOT_EXT_MULTI = 2'h3;
  // clock mode codes
  localparam logic [1:0] CLK_BYPASS = 2'h0;
  localparam logic [1:0] CLK_EXT_REF = 2'h1;
  localparam logic [1:0] CLK_CRYSTAL = 2'h2;
  localparam logic [1:0] CLK_ONE_TO_ONE = 2'h3;
  // register map, byte addresses
  localparam int ADR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  // status fields
  localparam int ST_BOOT_LSB = 0;
  localparam int ST_CLK_LSB = 2;
  localparam int ST_RANGE = 4;
  localparam int ST_PULL = 5;
  localparam int ST_EXTERNAL = 6;
  localparam int ST_RESET_OUT = 7;
  localparam int ST_BUSY = 8;
  // control fields
  localparam int CT_SOFT_RESET = 0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : rcl_pkg

// ==== rcl_seq_if.sv ====
// signals between the capture logic and the release timer
`timescale 1ns/10ps
interface rcl_seq_if;
  logic resetRequest;
  logic latchPulse;
  logic released;
  logic busy;
  modport ctl (output resetRequest, input latchPulse, input released, input busy);
  modport seq (input resetRequest, output latchPulse, output released, output busy);
endinterface : rcl_seq_if

// ==== rcl_release_timer.sv ====
// reset release counter with latch strobe ahead of release
`timescale 1ns/10ps
module rcl_release_timer #(
  parameter int RELEASE_CYCLES = 2404
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  rcl_seq_if.seq seq
);
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN = 3'b100
  } rcl_state_t;

  localparam logic [rcl_pkg::CNT_W-1:0] LOAD = rcl_pkg::CNT_W'(RELEASE_CYCLES - 1);
  localparam logic [rcl_pkg::CNT_W-1:0] LEAD = rcl_pkg::CNT_W'(rcl_pkg::LATCH_LEAD);

  rcl_state_t state_reg, state_next;
  logic [rcl_pkg::CNT_W-1:0] count_reg, count_next;
  logic released_reg, released_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!seq.resetRequest) begin
          state_next = ST_COUNT;
          count_next = LOAD;
        end
      end
      ST_COUNT: begin
        if (seq.resetRequest) begin
          state_next = ST_HOLD;
        end else if (count_reg == '0) begin
          state_next = ST_RUN;
        end else begin
          count_next = count_reg - 1'b1;
        end
      end
      ST_RUN: begin
        if (seq.resetRequest) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    released_next = (state_next == ST_RUN);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_HOLD;
      count_reg <= '0;
      released_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
      released_reg <= released_next;
    end
  end

  // strobe lands exactly LATCH_LEAD edges before released rises
  assign seq.latchPulse = (state_reg == ST_COUNT) && (count_reg == LEAD) && !seq.resetRequest;
  assign seq.released = released_reg;
  assign seq.busy = (state_reg != ST_RUN);
endmodule : rcl_release_timer

// ==== rcl_reset_config_latch.sv ====
// reset-time strap capture with reset output sequencing and register access
// Behaviour
// - the low-active config select pin picks built-in defaults when high, strap values when low.
// - the config select pin carries a weak internal pull-up so defaults apply when undriven.
// - with config select low, boot and clock straps are latched four clocks before reset output negates.
// - the timer pull strap is latched four clocks before reset output negates, whatever config select says.
// - a two-bit boot strap picks internal flash, external memory or serial boot.
// - a two-bit clock strap picks crystal or external reference, with a third bit for clock range.
// - the timer pull strap sets the default weak pull direction of the timer pins.
// - defaults are boot code 00 (internal flash) and clock code 10 (crystal).
// - boot codes are 00 flash, 01 serial, 10 external single master, 11 external multi-master.
// - clock codes are 00 bypass, 01 external reference, 10 crystal, 11 one-to-one.
// - a latched timer pull of 0 enables pull-downs and 1 enables pull-ups.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module rcl_reset_config_latch #(
  parameter int RELEASE_CYCLES = 2404,
  parameter bit HAS_CLOCK_RANGE = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic resetInN,
  input wire logic config_source_select_n,
  input wire logic [1:0] boot_source_strap,
  input wire logic [2:0] clock_mode_strap,
  input wire logic timer_pull_strap,
  output logic configSelectPullUpEn,
  output logic reset_output_n,
  output logic [1:0] bootSource,
  output logic [1:0] clockMode,
  output logic clockRange,
  output logic [3:0] bootDecoded,
  output logic [3:0] clockDecoded,
  output logic timerPullUpEn,
  output logic timerPullDownEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rcl_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // one-hot view of a two-bit code, bit n set for code n
  function automatic logic [3:0] decode2(input logic [1:0] code);
    decode2 = 4'h1 << code;
  endfunction : decode2

  rcl_seq_if seqBus ();

  rcl_release_timer #(
    .RELEASE_CYCLES(RELEASE_CYCLES)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .seq(seqBus.seq)
  );

  logic [1:0] boot_reg, boot_next;
  logic [1:0] clk_reg, clk_next;
  logic range_reg, range_next;
  logic pull_reg, pull_next;
  logic ext_reg, ext_next;
  logic soft_reg, soft_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic access;
  logic [31:0] statusWord;

  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  // a software reset request holds the output low until the timer restarts
  assign seqBus.resetRequest = !resetInN || soft_reg;

  always_comb begin
    statusWord = rcl_pkg::ZERO_WORD;
    statusWord[rcl_pkg::ST_BOOT_LSB +: 2] = boot_reg;
    statusWord[rcl_pkg::ST_CLK_LSB +: 2] = clk_reg;
    statusWord[rcl_pkg::ST_RANGE] = range_reg;
    statusWord[rcl_pkg::ST_PULL] = pull_reg;
    statusWord[rcl_pkg::ST_EXTERNAL] = ext_reg;
    statusWord[rcl_pkg::ST_RESET_OUT] = seqBus.released;
    statusWord[rcl_pkg::ST_BUSY] = seqBus.busy;
  end

  always_comb begin
    boot_next = boot_reg;
    clk_next = clk_reg;
    range_next = range_reg;
    pull_next = pull_reg;
    ext_next = ext_reg;
    if (seqBus.latchPulse) begin
      pull_next = timer_pull_strap;
      ext_next = !config_source_select_n;
      if (!config_source_select_n) begin
        boot_next = boot_source_strap;
        clk_next = clock_mode_strap[1:0];
        range_next = HAS_CLOCK_RANGE ? clock_mode_strap[2] : rcl_pkg::RANGE_DEFAULT;
      end else begin
        boot_next = rcl_pkg::BOOT_DEFAULT;
        clk_next = rcl_pkg::CLK_DEFAULT;
        range_next = rcl_pkg::RANGE_DEFAULT;
      end
    end
  end

  always_comb begin
    ack_next = access;
    dat_next = dat_reg;
    // request bit drops once the timer has taken it back into hold
    soft_next = soft_reg;
    if (seqBus.busy && !seqBus.released) begin
      soft_next = 1'b0;
    end
    if (access && !wb_we_i) begin
      dat_next = (wb_adr_i == rcl_pkg::OFS_STATUS) ? statusWord : rcl_pkg::ZERO_WORD;
    end
    if (access && wb_we_i && wb_adr_i == rcl_pkg::OFS_CONTROL && wb_sel_i[0]) begin
      soft_next = wb_dat_i[rcl_pkg::CT_SOFT_RESET];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_reg <= rcl_pkg::BOOT_DEFAULT;
      clk_reg <= rcl_pkg::CLK_DEFAULT;
      range_reg <= rcl_pkg::RANGE_DEFAULT;
      pull_reg <= 1'b0;
      ext_reg <= 1'b0;
      soft_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= rcl_pkg::ZERO_WORD;
    end else if (ce) begin
      boot_reg <= boot_next;
      clk_reg <= clk_next;
      range_reg <= range_next;
      pull_reg <= pull_next;
      ext_reg <= ext_next;
      soft_reg <= soft_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // pad pull-up is unconditional so an open pin selects defaults
  assign configSelectPullUpEn = 1'b1;
  assign reset_output_n = seqBus.released;
  assign bootSource = boot_reg;
  assign clockMode = clk_reg;
  assign clockRange = range_reg;
  assign bootDecoded = decode2(boot_reg);
  assign clockDecoded = decode2(clk_reg);
  assign timerPullUpEn = pull_reg;
  assign timerPullDownEn = !pull_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // helper: enabled cycles since the last latch strobe, saturating
  logic [3:0] latchAge_reg, latchAge_next;
  always_comb begin
    latchAge_next = latchAge_reg;
    if (seqBus.latchPulse) begin
      latchAge_next = 4'h1;
    end else if (latchAge_reg != 4'hF) begin
      latchAge_next = latchAge_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latchAge_reg <= 4'hF;
    end else if (ce) begin
      latchAge_reg <= latchAge_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_release_four_after: assert property ($rose(reset_output_n) |-> latchAge_reg == 4'(rcl_pkg::LATCH_LEAD + 1))
    else $error("reset output not released four clocks after latch");
  a_default_config_pick: assert property (ce && seqBus.latchPulse && config_source_select_n |=>
    bootSource == rcl_pkg::BOOT_FLASH && clockMode == rcl_pkg::CLK_CRYSTAL)
    else $error("default configuration not applied");
  a_external_config_pick: assert property (ce && seqBus.latchPulse && !config_source_select_n |=>
    bootSource == $past(boot_source_strap) && clockMode == $past(clock_mode_strap[1:0]))
    else $error("strap configuration not captured");
  a_timer_pull_capture: assert property (ce && seqBus.latchPulse |=> timerPullUpEn == $past(timer_pull_strap))
    else $error("timer pull strap not captured");
  a_config_held_run: assert property (reset_output_n && $past(reset_output_n) |->
    $stable(bootSource) && $stable(clockMode) && $stable(clockRange) && $stable(timerPullUpEn))
    else $error("latched configuration changed while running");
  a_reset_in_holds: assert property (ce && !resetInN |=> !reset_output_n)
    else $error("reset output released while reset input asserted");
  a_pull_direction: assert property (timerPullUpEn != timerPullDownEn && bootDecoded[bootSource])
    else $error("timer pull direction inconsistent");
  a_range_capture: assert property (ce && seqBus.latchPulse && !config_source_select_n && HAS_CLOCK_RANGE |=>
    clockRange == $past(clock_mode_strap[2]))
    else $error("clock range strap not captured");
  a_select_pullup: assert property (configSelectPullUpEn)
    else $error("config select pull-up disabled");
  a_clock_decode: assert property (clockDecoded[clockMode] && $onehot(clockDecoded))
    else $error("clock mode decode wrong");

  // the strobe is the only way the captured values may move
  a_latch_while_reset: assert property (seqBus.latchPulse |-> !reset_output_n)
    else $error("strap latch fired while reset output released");
  a_latch_once: assert property (ce && seqBus.latchPulse |=> !seqBus.latchPulse)
    else $error("strap latch strobe longer than one cycle");
  a_config_hold_idle: assert property (!(ce && seqBus.latchPulse) |=>
    $stable(bootSource) && $stable(clockMode) && $stable(clockRange) && $stable(timerPullUpEn))
    else $error("latched configuration changed without a latch strobe");
  a_pull_down_capture: assert property (ce && seqBus.latchPulse |=> timerPullDownEn == !$past(timer_pull_strap))
    else $error("timer pull-down enable not inverse of strap");
  a_ext_flag_capture: assert property (ce && seqBus.latchPulse |=> ext_reg == !$past(config_source_select_n))
    else $error("config source flag not captured");
  a_request_drops_out: assert property (ce && seqBus.resetRequest |=> !reset_output_n)
    else $error("reset output released during reset request");
  a_boot_decode: assert property (bootDecoded[bootSource] && $onehot(bootDecoded))
    else $error("boot source decode wrong");
  a_range_default: assert property (ce && seqBus.latchPulse && config_source_select_n |=>
    clockRange == rcl_pkg::RANGE_DEFAULT)
    else $error("default clock range not applied");
endmodule : rcl_reset_config_latch

// ==== rcl_board_straps.sv ====
// board side model: strap resistors and the config select pin
`timescale 1ns/10ps
module rcl_board_straps (
  input wire logic selDrive,
  input wire logic pullUpEn,
  input wire logic [1:0] bootVal,
  input wire logic [2:0] clkVal,
  input wire logic pullVal,
  output logic config_source_select_n,
  output logic [1:0] boot_source_strap,
  output logic [2:0] clock_mode_strap,
  output logic timer_pull_strap
);
  // undriven select pin only reads high if the device enables its pull-up
  assign config_source_select_n = selDrive ? 1'h0 : pullUpEn;
  assign boot_source_strap = bootVal;
  assign clock_mode_strap = clkVal;
  assign timer_pull_strap = pullVal;
endmodule : rcl_board_straps

// ==== tb_rcl_reset_config_latch.sv ====
// self-checking bench for the reset configuration latch
`timescale 1ns/10ps
module tb_rcl_reset_config_latch;
  localparam int RC = 10;
  logic clk, srst, ceIn, resetInN, selDrive, pullVal, wbCyc, wbStb, wbWe;
  logic [1:0] bootVal;
  logic [2:0] clkVal;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] rd, wbDatI;
  wire logic selN, pullStrap, pullUpEn, resetOutN, rng, tUp, tDown, ack;
  wire logic [1:0] bootStrap, boot, clkMode;
  wire logic [2:0] clkStrap;
  wire logic [3:0] bootDec, clkDec;
  wire logic [31:0] wbDatO;
  int nMismatch = 0;
  int nTests = 0;

  rcl_board_straps board (.selDrive(selDrive), .pullUpEn(pullUpEn), .bootVal(bootVal), .clkVal(clkVal),
    .pullVal(pullVal), .config_source_select_n(selN), .boot_source_strap(bootStrap),
    .clock_mode_strap(clkStrap), .timer_pull_strap(pullStrap));

  rcl_reset_config_latch #(.RELEASE_CYCLES(RC)) dut (.clk(clk), .srst(srst), .ce(ceIn), .resetInN(resetInN),
    .config_source_select_n(selN), .boot_source_strap(bootStrap), .clock_mode_strap(clkStrap),
    .timer_pull_strap(pullStrap), .configSelectPullUpEn(pullUpEn), .reset_output_n(resetOutN),
    .bootSource(boot), .clockMode(clkMode), .clockRange(rng), .bootDecoded(bootDec), .clockDecoded(clkDec),
    .timerPullUpEn(tUp), .timerPullDownEn(tDown), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(ack));

  task chk(input bit ok, input string msg);
    nTests++;
    if (!ok) begin
      nMismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task stop_test;
    if (nMismatch == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // request stands until ack is seen high at a rising edge; read data is taken there
  task wb_read(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= 1'h0;
    wbAdr <= a;
    wbSel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    d = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    chk(n < 20, "no bus answer");
  endtask : wb_read

  task wb_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= 1'h1;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatI <= d;
    @(posedge clk);
    while (ack !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
    chk(n < 20, "no bus answer on write");
  endtask : wb_write

  // software reset reruns the sequence; a frozen clock enable stretches the count
  task soft_cfg;
    selDrive <= 1'h1;
    bootVal <= 2'h2;
    clkVal <= 3'h5;
    pullVal <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(boot === rcl_pkg::BOOT_DEFAULT && clkMode === rcl_pkg::CLK_DEFAULT && tUp === 1'h1, "config moved");
    wb_write(rcl_pkg::OFS_CONTROL, 32'h0000_0001);
    #1 chk(resetOutN === 1'h0, "soft reset ignored");
    repeat (2) @(posedge clk);
    ceIn <= 1'h0;
    repeat (3) @(posedge clk);
    ceIn <= 1'h1;
    repeat (RC - 1) @(posedge clk);
    #1 chk(resetOutN === 1'h0, "released through frozen enable");
    @(posedge clk);
    #1 chk(resetOutN === 1'h1, "release late after freeze");
    chk(boot === 2'h2 && clkMode === 2'h1 && rng === 1'h1 && tUp === 1'h0 && tDown === 1'h1, "soft rerun");
    wb_read(rcl_pkg::OFS_CONTROL, rd);
    chk(rd === rcl_pkg::ZERO_WORD, "control reads back");
    wb_read(rcl_pkg::OFS_STATUS, rd);
    chk(rd[8:0] === {1'h0, 1'h1, 1'h1, 1'h0, 3'h5, 2'h2}, "status after soft reset");
  endtask : soft_cfg

  // straps show the wanted value only at the latch edge, the inverse elsewhere
  task run_cfg(input logic drv, input logic [1:0] b, input logic [2:0] c, input logic p,
               input logic [1:0] eb, input logic [2:0] ec);
    resetInN <= 1'h0;
    selDrive <= drv;
    bootVal <= ~b;
    clkVal <= ~c;
    pullVal <= ~p;
    repeat (2) @(posedge clk);
    #1 chk(resetOutN === 1'h0, "reset out not asserted");
    @(posedge clk);
    resetInN <= 1'h1;
    repeat (6) @(posedge clk);
    bootVal <= b;
    clkVal <= c;
    pullVal <= p;
    @(posedge clk);
    bootVal <= ~b;
    clkVal <= ~c;
    pullVal <= ~p;
    repeat (3) @(posedge clk);
    #1 chk(resetOutN === 1'h0, "reset out released early");
    @(posedge clk);
    #1 chk(resetOutN === 1'h1, "reset out released late");
    repeat (4) @(posedge clk);
    #1 chk(boot === eb && bootDec === (4'h1 << eb), "boot source");
    chk(clkMode === ec[1:0] && clkDec === (4'h1 << ec[1:0]) && rng === ec[2], "clock mode");
    chk(tUp === p && tDown === ~p, "timer pull");
    wb_read(rcl_pkg::OFS_STATUS, rd);
    chk(rd[8:0] === {1'h0, 1'h1, drv, p, ec, eb}, "status word");
  endtask : run_cfg

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    nMismatch++;
    stop_test();
  end

  initial begin
    srst = 1'h1;
    ceIn = 1'h1;
    wbDatI = 32'h0000_0000;
    resetInN = 1'h1;
    selDrive = 1'h0;
    bootVal = 2'h0;
    clkVal = 3'h0;
    pullVal = 1'h0;
    wbCyc = 1'h0;
    wbStb = 1'h0;
    wbWe = 1'h0;
    wbAdr = 4'h0;
    wbSel = 4'h0;
    repeat (15) @(posedge clk);
    #1 chk(resetOutN === 1'h0 && boot === rcl_pkg::BOOT_DEFAULT && clkMode === rcl_pkg::CLK_DEFAULT, "reset values");
    chk(pullUpEn === 1'h1, "select pull-up");
    @(posedge clk);
    srst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      run_cfg(1'h1, 2'(i), {i[0], 2'(3 - i)}, i[0], 2'(i), {i[0], 2'(3 - i)});
    end
    run_cfg(1'h0, 2'h3, 3'h5, 1'h1, rcl_pkg::BOOT_DEFAULT, {rcl_pkg::RANGE_DEFAULT, rcl_pkg::CLK_DEFAULT});
    soft_cfg();
    wb_read(4'h8, rd);
    chk(rd === rcl_pkg::ZERO_WORD, "unmapped read");
    stop_test();
  end
endmodule : tb_rcl_reset_config_latch
